// [pkg/ivp_pkg.sv]
// Constants, types and behaviour summary for the interrupt vector/priority block
// Behaviour
// - Simultaneous maskable requests in one group resolve by fixed order; 0 wins, 27 last.
// - Default order only breaks ties; never pre-empts a request in service.
// - First 16-bit timer match0/capture takes priority 14, vector 0020H.
// - First 16-bit timer match1/capture takes priority 15, vector 0022H.
// - Converter end-of-conversion takes priority 16, vector 0024H.
// - Serial0 receive-complete and receive-error merge into priority 17, 0026H.
// - Watch interval request takes priority 18, vector 0028H.
// - Second 8-bit timer compare match takes priority 19, vector 002AH.
// - Extra external pins take priorities 22 and 23, vectors 0030H, 0032H.
// - Multiplier/divider completion takes priority 24, vector 0034H.
// - Second clocked serial end takes priority 25, vector 0036H.
// - Second 16-bit timer requests take priorities 26, 27; vectors 0038H, 003AH.
// - Sources 25 to 27 exist only in the larger variant.
// - Every reset source vectors to 0000H.
// - Power-on clear acts only when enabled as a build option.
// - Low-voltage action bit 1: 0 gives priority-0 interrupt, 1 gives reset.
// - Requests in the same programmed group are served in default order.
// - Software break accepted while disabled, exempt from priority control.
// - Accepted source's pending flag clears before the service routine.
package ivp_pkg;
   localparam int          IVP_NSRC       = 28;
   localparam int          IVP_NSRC_SMALL = 25;
   localparam int          IVP_IDX_W      = 5;
   localparam logic [15:0] IVP_VEC_RESET  = 16'h0000;
   localparam logic [15:0] IVP_VEC_BASE   = 16'h0004;
   localparam logic [15:0] IVP_VEC_BRK    = 16'h003E;
   localparam int          IVP_LV_MODE_BIT = 1;
   localparam int          IVP_LV_CTRL_W   = 8;
   // Source positions in the priority list
   localparam int IVP_P_LVI     = 0;
   localparam int IVP_P_T16A_M0 = 14;
   localparam int IVP_P_T16A_M1 = 15;
   localparam int IVP_P_ADC     = 16;
   localparam int IVP_P_SER0    = 17;
   localparam int IVP_P_WINT    = 18;
   localparam int IVP_P_T8B     = 19;
   localparam int IVP_P_KEY     = 20;
   localparam int IVP_P_WOVF    = 21;
   localparam int IVP_P_PIN6    = 22;
   localparam int IVP_P_PIN7    = 23;
   localparam int IVP_P_MULDIV  = 24;
   localparam int IVP_P_CSI1    = 25;
   localparam int IVP_P_T16B_M0 = 26;
   localparam int IVP_P_T16B_M1 = 27;

   typedef struct packed {
      logic watchdog_overflow;
      logic osc_stop;
      logic low_voltage;
      logic power_on_clear;
      logic ext_reset;
   } ivp_rst_src_t;

   typedef struct packed {
      logic        valid;
      logic        is_brk;
      logic [4:0]  idx;
      logic [15:0] addr;
   } ivp_vec_t;

   typedef enum logic [1:0] {
      IVP_IDLE  = 2'b00,
      IVP_OFFER = 2'b01
   } ivp_state_t;
endpackage

// [verilog/ivp_core.sv]
// Interrupt source list: pending flags, priority pick and vector offer
`timescale 1ns/1ps
`default_nettype none
module ivp_core
   import ivp_pkg::*;
#(
   parameter int NSRC       = IVP_NSRC,
   parameter bit POC_OPTION = 1'b1
) (
   input  wire logic                     mclk_in,
   input  wire logic                     sys_rst_in,
   // Pulse per source, bit n at default priority n (bit 0 unused by peers)
   input  wire logic [IVP_NSRC-1:0]      src_req_in,
   input  wire logic                     serial0_error_in,
   input  wire logic [IVP_NSRC-1:0]      mask_in,
   input  wire logic [IVP_NSRC-1:0]      group_low_in,
   input  wire logic                     int_enable_in,
   input  wire logic                     in_service_in,
   input  wire logic                     in_service_high_in,
   input  wire logic                     low_voltage_detect_in,
   input  wire logic [IVP_LV_CTRL_W-1:0] low_voltage_control_reg_in,
   input  wire logic                     software_break_in,
   input  wire ivp_rst_src_t             reset_src_in,
   input  wire logic                     ack_in,
   output logic                          irq_req_out,
   output logic [15:0]                   vec_addr_out,
   output logic                          vec_brk_out,
   output logic [IVP_IDX_W-1:0]          vec_idx_out,
   output logic [IVP_NSRC-1:0]           pending_out,
   output logic                          reset_req_out,
   output logic [15:0]                   reset_vec_out
);
   initial begin
      if (NSRC != IVP_NSRC && NSRC != IVP_NSRC_SMALL)
         $error("ivp_core: NSRC must be 25 or 28");
   end

   // ----------------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------------
   function automatic logic [15:0] vec_of(input logic [IVP_IDX_W-1:0] i);
      vec_of = IVP_VEC_BASE + {10'h000, i, 1'b0};
   endfunction

   function automatic logic lv_is_reset(input logic [IVP_LV_CTRL_W-1:0] r);
      lv_is_reset = r[IVP_LV_MODE_BIT];
   endfunction

   // ----------------------------------------------------------------------
   // Source present only in the fitted variant
   // ----------------------------------------------------------------------
   logic [IVP_NSRC-1:0] fitted;
   genvar g;
   generate
      for (g = 0; g < IVP_NSRC; g++) begin : g_fit
         assign fitted[g] = (g < NSRC);
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Raw event map
   // ----------------------------------------------------------------------
   logic [IVP_NSRC-1:0] raw;
   always_comb begin
      raw = src_req_in & fitted;
      // Later sources ride the same map: bits 25 to 27
      raw = raw & fitted;
      // Merged receive events share one flag
      raw[IVP_P_SER0] = src_req_in[IVP_P_SER0] | serial0_error_in;
      // Low voltage acts as interrupt only in interrupt mode
      raw[IVP_P_LVI] = low_voltage_detect_in
                     & ~lv_is_reset(low_voltage_control_reg_in);
   end

   // ----------------------------------------------------------------------
   // Pending flags and offer state
   // ----------------------------------------------------------------------
   logic [IVP_NSRC-1:0] pend_q, pend_d;
   ivp_state_t          st_q, st_d;
   ivp_vec_t            off_q, off_d;
   logic                brk_q, brk_d;
   logic                rst_q, rst_d;

   // Priority pick: lowest index among eligible wins
   logic [IVP_NSRC-1:0] elig;
   logic                found;
   logic [IVP_IDX_W-1:0] win;
   logic                 use_high;
   always_comb begin
      elig  = pend_q & ~mask_in & fitted;
      // High group first; within a group default order decides
      use_high = |(elig & ~group_low_in);
      if (use_high) begin
         elig = elig & ~group_low_in;
      end
      // In-service work is never pre-empted by default order alone
      if (in_service_in && (in_service_high_in || !use_high)) begin
         elig = '0;
      end
      found = 1'b0;
      win   = '0;
      for (int i = IVP_NSRC - 1; i >= 0; i--) begin
         if (elig[i]) begin
            found = 1'b1;
            win   = IVP_IDX_W'(i);
         end
      end
   end

   always_comb begin
      pend_d = pend_q;
      st_d   = st_q;
      off_d  = off_q;
      brk_d  = brk_q | software_break_in;
      rst_d  = reset_src_in.ext_reset
             | (reset_src_in.power_on_clear & POC_OPTION)
             | ((reset_src_in.low_voltage | low_voltage_detect_in)
                & lv_is_reset(low_voltage_control_reg_in))
             | reset_src_in.osc_stop
             | reset_src_in.watchdog_overflow;
      unique case (st_q)
         IVP_IDLE: begin
            if (brk_q) begin
               // Break ignores the enable and the priority pick
               off_d = '{valid: 1'b1, is_brk: 1'b1, idx: '0,
                         addr: IVP_VEC_BRK};
               st_d  = IVP_OFFER;
            end else if (int_enable_in && found) begin
               off_d = '{valid: 1'b1, is_brk: 1'b0, idx: win,
                         addr: vec_of(win)};
               st_d  = IVP_OFFER;
            end
         end
         IVP_OFFER: begin
            if (ack_in) begin
               // Flag drops on acceptance, before the routine runs
               if (off_q.is_brk) begin
                  brk_d = software_break_in;
               end else begin
                  pend_d[off_q.idx] = 1'b0;
               end
               off_d = '0;
               st_d  = IVP_IDLE;
            end
         end
         default: begin
            // Unused state code: drop any offer and start over
            off_d = '0;
            st_d  = IVP_IDLE;
         end
      endcase
      // New events win over the acknowledge clear
      pend_d = pend_d | raw;
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pend_q <= '0;
         st_q   <= IVP_IDLE;
         off_q  <= '0;
         brk_q  <= 1'b0;
         rst_q  <= 1'b0;
      end else begin
         pend_q <= pend_d;
         st_q   <= st_d;
         off_q  <= off_d;
         brk_q  <= brk_d;
         rst_q  <= rst_d;
      end
   end

   always_comb begin
      irq_req_out   = off_q.valid;
      vec_addr_out  = off_q.addr;
      vec_brk_out   = off_q.is_brk;
      vec_idx_out   = off_q.idx;
      pending_out   = pend_q;
      reset_req_out = rst_q;
      reset_vec_out = IVP_VEC_RESET;
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   property p_hold;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (irq_req_out && !ack_in) |=> (irq_req_out && $stable(vec_addr_out));
   endproperty
   a_hold: assert property (p_hold) else $error("vector moved before ack");

   property p_clear;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (irq_req_out && ack_in && !vec_brk_out && !raw[vec_idx_out])
         |=> !pending_out[$past(vec_idx_out)];
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");

   property p_vec;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (irq_req_out && !vec_brk_out)
         |-> vec_addr_out == IVP_VEC_BASE + {10'h000, vec_idx_out, 1'b0};
   endproperty
   a_vec: assert property (p_vec) else $error("bad vector address");

   property p_brk;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (st_q == IVP_IDLE && brk_q) |=> (vec_brk_out && vec_addr_out == IVP_VEC_BRK);
   endproperty
   a_brk: assert property (p_brk) else $error("break not taken");

   logic [IVP_NSRC-1:0] elig_q_low;
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) elig_q_low <= '0;
      else            elig_q_low <= elig;
   end
   property p_prio;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (st_q == IVP_IDLE && !brk_q && int_enable_in && found)
         |=> ((elig_q_low & ((32'h1 << vec_idx_out) - 1)) == 0);
   endproperty
   a_prio: assert property (p_prio) else $error("lower priority won");

   property p_small;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (NSRC == IVP_NSRC_SMALL) |-> (pending_out[IVP_P_T16B_M1:IVP_P_CSI1] == 3'h0);
   endproperty
   a_small: assert property (p_small) else $error("absent source pending");

   property p_lvmode;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (low_voltage_detect_in && lv_is_reset(low_voltage_control_reg_in))
         |=> reset_req_out;
   endproperty
   a_lvmode: assert property (p_lvmode) else $error("lv reset lost");

   property p_ser;
      @(posedge mclk_in) disable iff (sys_rst_in)
      serial0_error_in |=> pending_out[IVP_P_SER0];
   endproperty
   a_ser: assert property (p_ser) else $error("rx error not merged");

   property p_poc;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (!POC_OPTION && reset_src_in == 5'h02) |=> !reset_req_out;
   endproperty
   a_poc: assert property (p_poc) else $error("poc acted unselected");
endmodule
`default_nettype wire

// [bench/ivp_core_model.sv]
// Processor-core model that accepts vectored interrupt offers
`timescale 1ns/1ps
`default_nettype none
module ivp_core_model (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        irq_in,
   input  wire logic [15:0] addr_in,
   input  wire logic        brk_in,
   input  wire logic [4:0]  idx_in,
   input  wire logic [3:0]  delay_in,
   output logic             ack_out,
   output logic             got_out,
   output logic [15:0]      got_addr_out,
   output logic             got_brk_out,
   output logic [4:0]       got_idx_out
);
   logic [3:0] wait_q;
   // ----------------
   // Acknowledge
   // ----------------
   // Ack is held until the edge that samples it; the vector is taken there
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_out <= 1'b0;
         got_out <= 1'b0;
         wait_q  <= 4'h0;
      end else if (ack_out) begin
         ack_out      <= 1'b0;
         got_out      <= 1'b1;
         got_addr_out <= addr_in;
         got_brk_out  <= brk_in;
         got_idx_out  <= idx_in;
         wait_q       <= 4'h0;
      end else begin
         got_out <= 1'b0;
         if (irq_in && wait_q >= delay_in) ack_out <= 1'b1;
         else if (irq_in) wait_q <= wait_q + 4'h1;
      end
   end
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the interrupt source list
`timescale 1ns/1ps
`default_nettype none
module tb import ivp_pkg::*; ();
   logic         mclk_in = 1'b0;
   logic         sys_rst_in = 1'b1;
   logic [27:0]  req, mask, grp, pend;
   bit   [27:0]  exp_p;
   logic         ser_err, ie, ins, ins_hi, lvd, software_break, ack, irq, vbrk, rreq;
   logic         got, gbrk;
   logic [7:0]   lvc;
   logic [15:0]  vaddr, rvec, gaddr;
   logic [4:0]   vidx, gidx;
   logic [3:0]   dly;
   ivp_rst_src_t rsrc;
   int           mismatches = 0;
   int           check_count = 0;

   ivp_core dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .src_req_in(req),
      .serial0_error_in(ser_err), .mask_in(mask), .group_low_in(grp),
      .int_enable_in(ie), .in_service_in(ins), .in_service_high_in(ins_hi),
      .low_voltage_detect_in(lvd), .low_voltage_control_reg_in(lvc),
      .software_break_in(software_break), .reset_src_in(rsrc), .ack_in(ack),
      .irq_req_out(irq), .vec_addr_out(vaddr), .vec_brk_out(vbrk),
      .vec_idx_out(vidx), .pending_out(pend), .reset_req_out(rreq),
      .reset_vec_out(rvec));
   ivp_core_model core (.clk_in(mclk_in), .rst_in(sys_rst_in), .irq_in(irq),
      .addr_in(vaddr), .brk_in(vbrk), .idx_in(vidx), .delay_in(dly),
      .ack_out(ack), .got_out(got), .got_addr_out(gaddr),
      .got_brk_out(gbrk), .got_idx_out(gidx));

   initial forever #10 mclk_in = ~mclk_in;

   // ----------------
   // Checking tasks
   // ----------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp_val(input string nm, input logic [27:0] e, s);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cmp_vec(input int i, input bit b);
      int n;
      n = 0;
      do begin
         @(posedge mclk_in);
         #1;
         n++;
      end while (got !== 1'b1 && n < 80);
      cmp_val("offer", 28'h1, 28'(got));
      cmp_val("addr", b ? 28'h3E : 28'(16'h0004 + 16'(2 * i)), 28'(gaddr));
      cmp_val("brk", 28'(b), 28'(gbrk));
      if (!b) cmp_val("idx", 28'(i), 28'(gidx));
   endtask
   task automatic pulse(input logic [27:0] r);
      @(posedge mclk_in);
      req <= r;
      @(posedge mclk_in);
      req <= '0;
   endtask
   // Reference pick: high group first, then lowest default priority
   function automatic int pick(input bit [27:0] p, m, g);
      for (int h = 0; h < 2; h++)
         for (int i = 0; i < 28; i++)
            if (p[i] && !m[i] && g[i] == h[0]) return i;
      return -1;
   endfunction
   task automatic serve();
      int w;
      #1;
      w = pick(exp_p, mask, grp);
      while (w >= 0) begin
         cmp_vec(w, 1'b0);
         exp_p[w] = 1'b0;
         w = pick(exp_p, mask, grp);
      end
   endtask
   task automatic idle_check();
      repeat (5) @(posedge mclk_in);
      #1;
      cmp_val("irq", 28'h0, 28'(irq));
   endtask

   initial begin
      repeat (60000) @(posedge mclk_in);
      mismatches++;
      print_verdict();
   end

   initial begin
      {req, mask, grp, exp_p, ser_err, ins, ins_hi, lvd, software_break} = '0;
      {lvc, rsrc, dly, ie} = 18'h1;
      void'($urandom(32'hE2830CDA));
      repeat (12) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      #1;
      cmp_val("rvec", 28'h0, 28'(rvec));
      for (int i = 14; i < 28; i++) begin
         pulse(28'h1 << i);
         cmp_vec(i, 1'b0);
      end
      @(posedge mclk_in);
      ser_err <= 1'b1;
      @(posedge mclk_in);
      ser_err <= 1'b0;
      cmp_vec(17, 1'b0);
      for (int t = 0; t < 40; t++) begin
         @(posedge mclk_in);
         mask <= 28'($urandom & $urandom & $urandom);
         grp <= 28'($urandom);
         dly <= 4'($urandom % 4);
         exp_p = 28'($urandom) & 28'hFFFFFFE;
         pulse(exp_p);
         serve();
         @(posedge mclk_in);
         #1;
         cmp_val("pending", exp_p, pend);
         mask <= '0;
         serve();
      end
      dly <= 4'h6;
      pulse(28'h1 << 20);
      pulse(28'h1 << 14);
      cmp_vec(20, 1'b0);
      cmp_vec(14, 1'b0);
      @(posedge mclk_in);
      ie <= 1'b0;
      software_break <= 1'b1;
      req <= 28'h1 << 16;
      @(posedge mclk_in);
      software_break <= 1'b0;
      req <= '0;
      cmp_vec(0, 1'b1);
      idle_check();
      ie <= 1'b1;
      cmp_vec(16, 1'b0);
      @(posedge mclk_in);
      ins <= 1'b1;
      ins_hi <= 1'b1;
      pulse(28'h1 << 22);
      idle_check();
      ins <= 1'b0;
      cmp_vec(22, 1'b0);
      @(posedge mclk_in);
      lvd <= 1'b1;
      @(posedge mclk_in);
      lvd <= 1'b0;
      cmp_vec(0, 1'b0);
      lvc <= 8'h02;
      lvd <= 1'b1;
      repeat (3) @(posedge mclk_in);
      #1;
      cmp_val("lv_reset", 28'h1, 28'({pend[0], rreq}));
      lvd <= 1'b0;
      for (int b = 0; b < 5; b++) begin
         @(posedge mclk_in);
         rsrc <= ivp_rst_src_t'(5'h01 << b);
         repeat (2) @(posedge mclk_in);
         #1;
         cmp_val("reset_req", 28'h1, 28'(rreq));
         rsrc <= '0;
         repeat (3) @(posedge mclk_in);
         #1;
         cmp_val("reset_req", 28'h0, 28'(rreq));
      end
      print_verdict();
   end
endmodule
`default_nettype wire
